/* hdl/ccp_capture_compare_ctrl.sv */
// Two capture/compare units, shared timers and AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "ccp_params.svh"
module ccp_capture_compare_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic first_unit_pin_in,
  output logic first_unit_pin_out,
  output logic first_unit_pin_oe_n,
  input wire logic alt_pin_port_c_in,
  output logic alt_pin_port_c_out,
  output logic alt_pin_port_c_oe_n,
  input wire logic alt_pin_port_b_in,
  output logic alt_pin_port_b_out,
  output logic alt_pin_port_b_oe_n,
  input wire logic pin_select,
  input wire logic adc_enabled,
  output logic adc_start
);
  logic aw_hold_r, aw_hold_nxt;
  logic w_hold_r, w_hold_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_go;

  logic [5:0] ctrl0_r, ctrl0_nxt;
  logic [5:0] ctrl1_r, ctrl1_nxt;
  logic [1:0] flags_r, flags_nxt;
  logic [15:0] timer_r, timer_nxt;
  logic [7:0] period_r, period_nxt;
  logic [1:0] tctrl_r, tctrl_nxt;
  logic [9:0] mod_r, mod_nxt;
  logic mod_start;
  logic adc_start_r, adc_start_nxt;

  logic [1:0] hold0_wstrb, hold1_wstrb;
  logic [15:0] hold0, hold1;
  logic [1:0] flag_set, special;
  logic unit1_pin_in, unit1_pin_out, unit1_pin_oe_n;

  // Bus write side: address and data taken in either order
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    wr_go = aw_hold_r && w_hold_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      // Unaligned or out-of-range address: error response, nothing written
      if (aw_addr_r[1:0] != 2'b00 || aw_addr_r > `CCP_OFF_TCTRL) begin
        bresp_nxt = `CCP_RESP_SLVERR;
      end else begin
        bresp_nxt = `CCP_RESP_OKAY;
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `CCP_RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // Readies stay low while a response waits, so one write is in flight
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Bus read side: data one edge after the address is taken
  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `CCP_RESP_OKAY;
      if (s_axi_araddr == `CCP_OFF_CTRL0) begin
        rdata_nxt = {26'h0, ctrl0_r};
      end else if (s_axi_araddr == `CCP_OFF_CTRL1) begin
        rdata_nxt = {26'h0, ctrl1_r};
      end else if (s_axi_araddr == `CCP_OFF_HOLD0) begin
        rdata_nxt = {16'h0, hold0};
      end else if (s_axi_araddr == `CCP_OFF_HOLD1) begin
        rdata_nxt = {16'h0, hold1};
      end else if (s_axi_araddr == `CCP_OFF_FLAGS) begin
        rdata_nxt = {30'h0, flags_r};
      end else if (s_axi_araddr == `CCP_OFF_TIMER) begin
        rdata_nxt = {16'h0, timer_r};
      end else if (s_axi_araddr == `CCP_OFF_PERIOD) begin
        rdata_nxt = {24'h0, period_r};
      end else if (s_axi_araddr == `CCP_OFF_TCTRL) begin
        rdata_nxt = {30'h0, tctrl_r};
      end else begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = `CCP_RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= `CCP_RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else begin
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // Control, flags and timers
  always_comb begin
    ctrl0_nxt = ctrl0_r;
    ctrl1_nxt = ctrl1_r;
    flags_nxt = flags_r;
    timer_nxt = timer_r;
    period_nxt = period_r;
    tctrl_nxt = tctrl_r;
    hold0_wstrb = 2'b00;
    hold1_wstrb = 2'b00;
    if (wr_go) begin
      if (aw_addr_r == `CCP_OFF_CTRL0 && w_strb_r[0]) begin
        ctrl0_nxt = w_data_r[5:0];
      end else if (aw_addr_r == `CCP_OFF_CTRL1 && w_strb_r[0]) begin
        ctrl1_nxt = w_data_r[5:0];
      end else if (aw_addr_r == `CCP_OFF_HOLD0) begin
        hold0_wstrb = w_strb_r[1:0];
      end else if (aw_addr_r == `CCP_OFF_HOLD1) begin
        hold1_wstrb = w_strb_r[1:0];
      end else if (aw_addr_r == `CCP_OFF_FLAGS && w_strb_r[0]) begin
        flags_nxt = flags_r & ~w_data_r[1:0];
      end else if (aw_addr_r == `CCP_OFF_TIMER) begin
        if (w_strb_r[0]) begin
          timer_nxt[7:0] = w_data_r[7:0];
        end
        if (w_strb_r[1]) begin
          timer_nxt[15:8] = w_data_r[15:8];
        end
      end else if (aw_addr_r == `CCP_OFF_PERIOD && w_strb_r[0]) begin
        period_nxt = w_data_r[7:0];
      end else if (aw_addr_r == `CCP_OFF_TCTRL && w_strb_r[0]) begin
        tctrl_nxt = w_data_r[1:0];
      end
    end
    // Hardware set beats a same-cycle software clear
    flags_nxt = flags_nxt | flag_set;
    if (!(wr_go && aw_addr_r == `CCP_OFF_TIMER) && tctrl_r[0]) begin
      timer_nxt = timer_r + 16'h0001;
    end
    if (|special) begin
      timer_nxt = 16'h0000;
    end
    // Fine count below the 8-bit timer gives the two duty LSBs a slot
    mod_start = 1'b0;
    mod_nxt = mod_r;
    if (tctrl_r[1]) begin
      if (mod_r[9:2] >= period_r && mod_r[1:0] == `CCP_FINE_LAST) begin
        mod_nxt = 10'h000;
        mod_start = 1'b1;
      end else begin
        mod_nxt = mod_r + 10'h001;
      end
    end
    // Converter start comes from the second unit only
    adc_start_nxt = special[1] && adc_enabled;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_r <= `CCP_CTRL_RESET;
      ctrl1_r <= `CCP_CTRL_RESET;
      flags_r <= 2'b00;
      timer_r <= 16'h0000;
      period_r <= 8'h00;
      tctrl_r <= 2'b00;
      mod_r <= 10'h000;
      adc_start_r <= 1'b0;
    end else begin
      ctrl0_r <= ctrl0_nxt;
      ctrl1_r <= ctrl1_nxt;
      flags_r <= flags_nxt;
      timer_r <= timer_nxt;
      period_r <= period_nxt;
      tctrl_r <= tctrl_nxt;
      mod_r <= mod_nxt;
      adc_start_r <= adc_start_nxt;
    end
  end

  assign adc_start = adc_start_r;

  // Both units see one shared timer and one modulation count
  ccp_unit u_first (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(ctrl0_r[3:0]),
    .duty_lsb(ctrl0_r[`CCP_DUTY_MSB:`CCP_DUTY_LSB]),
    .hold_wstrb(hold0_wstrb),
    .hold_wdata(w_data_r[15:0]),
    .timer(timer_r),
    .mod_count(mod_r),
    .mod_period_start(mod_start),
    .pin_in(first_unit_pin_in),
    .hold(hold0),
    .pin_out(first_unit_pin_out),
    .pin_oe_n(first_unit_pin_oe_n),
    .flag_set(flag_set[0]),
    .special(special[0])
  );

  ccp_unit u_second (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(ctrl1_r[3:0]),
    .duty_lsb(ctrl1_r[`CCP_DUTY_MSB:`CCP_DUTY_LSB]),
    .hold_wstrb(hold1_wstrb),
    .hold_wdata(w_data_r[15:0]),
    .timer(timer_r),
    .mod_count(mod_r),
    .mod_period_start(mod_start),
    .pin_in(unit1_pin_in),
    .hold(hold1),
    .pin_out(unit1_pin_out),
    .pin_oe_n(unit1_pin_oe_n),
    .flag_set(flag_set[1]),
    .special(special[1])
  );

  // Unselected alternate pin is released
  assign unit1_pin_in = pin_select ? alt_pin_port_b_in : alt_pin_port_c_in;
  assign alt_pin_port_c_out = unit1_pin_out;
  assign alt_pin_port_b_out = unit1_pin_out;
  assign alt_pin_port_c_oe_n = pin_select | unit1_pin_oe_n;
  assign alt_pin_port_b_oe_n = !pin_select | unit1_pin_oe_n;
endmodule

/* hdl/ccp_params.svh */
// Offsets, field positions, codes and reset values of the capture/compare block
// Operation
// - Mode zero switches unit off, resets state
// - Codes 0001 and 0011 select nothing
// - Capture on fall, rise, 4th, 16th rise
// - Code 0010 toggles pin, flags on match
// - Codes 1000/1001 set/clear pin, flag match
// - Code 1010 flags only, pin untouched
// - Code 1011 flags, clears timer, starts conversion
// - Only second unit starts a conversion
// - Duty bits are two duty LSBs
// - Capture copies whole timer into holding pair
// - Capture sets flag; only software clears
// - Newer capture overwrites unread value
// - Modulation outputs share period, aligned rises
// - Special event in either unit clears timer
// - Pin sampled even while driven
// - Second unit pin routed to one of two
// - Control bits 7-6 read zero; reset zero
// - Compare timer against holding word each cycle
// - Prescaler cleared when off or not capturing
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH
`define CCP_OFF_CTRL0 8'h00
`define CCP_OFF_CTRL1 8'h04
`define CCP_OFF_HOLD0 8'h08
`define CCP_OFF_HOLD1 8'h0c
`define CCP_OFF_FLAGS 8'h10
`define CCP_OFF_TIMER 8'h14
`define CCP_OFF_PERIOD 8'h18
`define CCP_OFF_TCTRL 8'h1c
`define CCP_CTRL_RESET 6'h00
`define CCP_DUTY_MSB 5
`define CCP_DUTY_LSB 4
`define CCP_M_OFF 4'h0
`define CCP_M_TOGGLE 4'h2
`define CCP_M_FALL 4'h4
`define CCP_M_RISE 4'h5
`define CCP_M_RISE4 4'h6
`define CCP_M_RISE16 4'h7
`define CCP_M_SET 4'h8
`define CCP_M_CLEAR 4'h9
`define CCP_M_SOFT 4'ha
`define CCP_M_SPECIAL 4'hb
`define CCP_PRE4_LAST 4'h3
`define CCP_PRE16_LAST 4'hf
`define CCP_FINE_LAST 2'h3
`define CCP_RESP_OKAY 2'h0
`define CCP_RESP_SLVERR 2'h2
`endif

/* hdl/ccp_pkg.sv */
// Types shared by the capture/compare files
package ccp_pkg;
  typedef enum logic [2:0] {
    CCP_FN_OFF,
    CCP_FN_RSVD,
    CCP_FN_CAP,
    CCP_FN_CMP,
    CCP_FN_PWM
  } ccp_func_t;
endpackage

/* hdl/ccp_unit.sv */
// One capture/compare/modulation channel
`timescale 1ns/1ps
`include "ccp_params.svh"
module ccp_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] mode,
  input wire logic [1:0] duty_lsb,
  input wire logic [1:0] hold_wstrb,
  input wire logic [15:0] hold_wdata,
  input wire logic [15:0] timer,
  input wire logic [9:0] mod_count,
  input wire logic mod_period_start,
  input wire logic pin_in,
  output logic [15:0] hold,
  output logic pin_out,
  output logic pin_oe_n,
  output logic flag_set,
  output logic special
);
  ccp_pkg::ccp_func_t func;
  logic sync1_r, sync2_r, prev_r, match_prev_r, pin_r;
  logic sync1_nxt, sync2_nxt, prev_nxt, match_prev_nxt, pin_nxt;
  logic [3:0] pre_r, pre_nxt;
  logic [15:0] hold_r, hold_nxt;
  logic [9:0] duty_r, duty_nxt;
  logic rise, fall, cap_ev, match, hit;

  always_comb begin
    if (mode == `CCP_M_OFF) begin
      func = ccp_pkg::CCP_FN_OFF;
    end else if (mode[3:2] == 2'b11) begin
      func = ccp_pkg::CCP_FN_PWM;
    end else if (mode[3:2] == 2'b01) begin
      func = ccp_pkg::CCP_FN_CAP;
    end else if (mode == `CCP_M_TOGGLE || mode[3:2] == 2'b10) begin
      func = ccp_pkg::CCP_FN_CMP;
    end else begin
      func = ccp_pkg::CCP_FN_RSVD;
    end
  end

  always_comb begin
    // Pad level is read whatever drives it, so own writes can capture
    sync1_nxt = pin_in;
    sync2_nxt = sync1_r;
    prev_nxt = sync2_r;
    rise = sync2_r & ~prev_r;
    fall = ~sync2_r & prev_r;
    cap_ev = 1'b0;
    pre_nxt = pre_r;
    if (func != ccp_pkg::CCP_FN_CAP) begin
      pre_nxt = 4'h0;
    end else begin
      case (mode)
        `CCP_M_FALL: cap_ev = fall;
        `CCP_M_RISE: cap_ev = rise;
        `CCP_M_RISE4: cap_ev = rise && pre_r == `CCP_PRE4_LAST;
        default: cap_ev = rise && pre_r == `CCP_PRE16_LAST;
      endcase
      if (rise && mode[1]) begin
        pre_nxt = cap_ev ? 4'h0 : pre_r + 4'h1;
      end
    end
    match = func == ccp_pkg::CCP_FN_CMP && timer == hold_r;
    // Edge of equality so a stopped timer flags once
    hit = match & ~match_prev_r;
    match_prev_nxt = match;
    special = hit && mode == `CCP_M_SPECIAL;
    flag_set = cap_ev | hit;
    hold_nxt = hold_r;
    if (hold_wstrb[0]) begin
      hold_nxt[7:0] = hold_wdata[7:0];
    end
    if (hold_wstrb[1]) begin
      hold_nxt[15:8] = hold_wdata[15:8];
    end
    if (cap_ev) begin
      hold_nxt = timer;
    end
    duty_nxt = duty_r;
    if (mod_period_start) begin
      duty_nxt = {hold_r[7:0], duty_lsb};
    end
    pin_nxt = pin_r;
    case (func)
      ccp_pkg::CCP_FN_CMP: begin
        if (hit && mode == `CCP_M_TOGGLE) begin
          pin_nxt = ~pin_r;
        end else if (hit && mode == `CCP_M_SET) begin
          pin_nxt = 1'b1;
        end else if (hit && mode == `CCP_M_CLEAR) begin
          pin_nxt = 1'b0;
        end
      end
      ccp_pkg::CCP_FN_PWM: pin_nxt = mod_count < duty_r;
      ccp_pkg::CCP_FN_CAP: pin_nxt = pin_r;
      default: pin_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      match_prev_r <= 1'b0;
      pin_r <= 1'b0;
      pre_r <= 4'h0;
      hold_r <= 16'h0000;
      duty_r <= 10'h000;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r <= prev_nxt;
      match_prev_r <= match_prev_nxt;
      pin_r <= pin_nxt;
      pre_r <= pre_nxt;
      hold_r <= hold_nxt;
      duty_r <= duty_nxt;
    end
  end

  assign hold = hold_r;
  assign pin_out = pin_r;
  assign pin_oe_n = !(func == ccp_pkg::CCP_FN_CMP || func == ccp_pkg::CCP_FN_PWM);
endmodule

/* sim/ccp_pin_model.sv */
// External signal source on the capture pins of both units
`timescale 1ns/1ps
module ccp_pin_model (
  input wire logic aclk,
  output logic ext0,
  output logic ext1
);
  initial begin
    ext0 = 1'b0;
    ext1 = 1'b0;
  end
  // Level change after dly edges; a long dly stands for a slow source
  task automatic level(input bit u, input logic v, input int dly);
    repeat (dly) @(posedge aclk);
    if (u) ext1 <= v;
    else ext0 <= v;
  endtask
endmodule

/* sim/ccp_cc_properties.sv */
// Port-level assertions for the capture/compare block
`timescale 1ns/1ps
module ccp_cc_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic first_unit_pin_out,
  input wire logic first_unit_pin_oe_n,
  input wire logic alt_pin_port_c_out,
  input wire logic alt_pin_port_c_oe_n,
  input wire logic alt_pin_port_b_out,
  input wire logic alt_pin_port_b_oe_n,
  input wire logic pin_select,
  input wire logic adc_enabled,
  input wire logic adc_start
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  adc_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  adc_gate_a: assert property (adc_start |-> $past(adc_enabled))
    else $error("conversion start with converter disabled");
  pad_b_sel_a: assert property (!alt_pin_port_b_oe_n |-> pin_select)
    else $error("unselected pad b driven");
  pad_c_sel_a: assert property (!alt_pin_port_c_oe_n |-> !pin_select)
    else $error("unselected pad c driven");
  pad_same_a: assert property (alt_pin_port_c_out == alt_pin_port_b_out)
    else $error("pads disagree");
  reset_idle_a: assert property (disable iff (1'b0) !aresetn |=>
    first_unit_pin_oe_n && !first_unit_pin_out && !adc_start)
    else $error("outputs not idle after reset");
endmodule
bind ccp_capture_compare_ctrl ccp_cc_properties chk_i (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .first_unit_pin_out, .first_unit_pin_oe_n, .alt_pin_port_c_out,
  .alt_pin_port_c_oe_n, .alt_pin_port_b_out, .alt_pin_port_b_oe_n, .pin_select,
  .adc_enabled, .adc_start);

/* sim/testbench.sv */
// Self-checking bench for the capture/compare block
`timescale 1ns/1ps
`include "ccp_params.svh"
module testbench;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, rv;
  logic sel = 0, adc_en = 0, awr, wr_rdy, bv, arr, rvld, adc_st;
  logic [1:0] bresp, rresp;
  logic p0o, p0e, pco, pce, pbo, pbe, e0, e1;
  int n_mismatch = 0, check_count = 0, n_adc = 0;
  always #50 aclk = ~aclk;
  always @(posedge aclk) if (adc_st === 1'b1) n_adc <= n_adc + 1;
  ccp_pin_model pm (.aclk(aclk), .ext0(e0), .ext1(e1));
  // Pad level: own drive while enabled, else the outside signal; pad c has a pull-down
  ccp_capture_compare_ctrl dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rvld), .s_axi_rready(rry),
    .first_unit_pin_in(p0e ? e0 : p0o), .first_unit_pin_out(p0o), .first_unit_pin_oe_n(p0e),
    .alt_pin_port_c_in(pce ? 1'b0 : pco), .alt_pin_port_c_out(pco), .alt_pin_port_c_oe_n(pce),
    .alt_pin_port_b_in(pbe ? e1 : pbo), .alt_pin_port_b_out(pbo), .alt_pin_port_b_oe_n(pbe),
    .pin_select(sel), .adc_enabled(adc_en), .adc_start(adc_st));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && awr === 1'b1) begin
        ad = 1;
        awv <= 0;
      end
      if (!dd && wr_rdy === 1'b1) begin
        dd = 1;
        wv <= 0;
      end
    end
    do @(posedge aclk); while (bv !== 1'b1);
    bry <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge aclk); while (rvld !== 1'b1);
    rv = rdat;
    rry <= 0;
  endtask
  task automatic reg_test();
    rd(`CCP_OFF_CTRL0);
    chk("ctrl0_reset", 0, rv);
    wr(`CCP_OFF_CTRL0, 32'hff);
    rd(`CCP_OFF_CTRL0);
    chk("ctrl0_rw", 32'h3f, rv);
    chk("pwm_oe_n", 0, 32'(p0e));
    wr(`CCP_OFF_CTRL0, 32'h0);
    chk("off_oe_n", 1, 32'(p0e));
    wr(`CCP_OFF_CTRL0, 32'hc);
    chk("pwm_low_oe_n", 0, 32'(p0e));
    wr(`CCP_OFF_CTRL0, 32'h1);
    chk("rsvd_oe_n", 1, 32'(p0e));
    rd(8'h20);
    chk("bad_rresp", 32'(`CCP_RESP_SLVERR), 32'(rresp));
    chk("bad_rdata", 0, rv);
    wr(8'h22, 32'h5);
    chk("bad_bresp", 32'(`CCP_RESP_SLVERR), 32'(bresp));
  endtask
  task automatic cap_test();
    logic [3:0] m [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
    int n [4] = '{1, 2, 4, 16};
    logic [15:0] tr, prev;
    prev = 0;
    for (int k = 0; k < 4; k++) begin
      wr(`CCP_OFF_CTRL0, 0);
      wr(`CCP_OFF_CTRL0, {28'h0, m[k]});
      for (int i = 1; i <= n[k]; i++) begin
        if (i == n[k] && m[k][1]) begin
          rd(`CCP_OFF_HOLD0);
          chk("hold0_pre", {16'h0, prev}, rv);
        end
        tr = {m[k], 4'h0, 8'(i)};
        wr(`CCP_OFF_TIMER, {16'h0, tr});
        pm.level(0, 1, 1);
        repeat (6) @(posedge aclk);
        wr(`CCP_OFF_TIMER, {16'h0, ~tr});
        pm.level(0, 0, 1);
        repeat (6) @(posedge aclk);
      end
      // Only the falling-edge mode holds the value written before the fall
      prev = (m[k] == `CCP_M_FALL) ? ~tr : tr;
      rd(`CCP_OFF_HOLD0);
      chk("hold0", {16'h0, prev}, rv);
      rd(`CCP_OFF_FLAGS);
      chk("cap_flag", 1, rv & 32'h1);
      wr(`CCP_OFF_FLAGS, 32'h3);
    end
    rd(`CCP_OFF_FLAGS);
    chk("flag_clear", 0, rv);
    // Unit 1 captures only through the selected pad
    sel <= 1;
    wr(`CCP_OFF_CTRL1, 5);
    wr(`CCP_OFF_TIMER, 32'h777);
    pm.level(1, 1, 2);
    pm.level(1, 0, 6);
    repeat (6) @(posedge aclk);
    rd(`CCP_OFF_HOLD1);
    chk("hold1_sel", 32'h777, rv);
    sel <= 0;
    wr(`CCP_OFF_TIMER, 32'h888);
    pm.level(1, 1, 2);
    pm.level(1, 0, 6);
    repeat (6) @(posedge aclk);
    rd(`CCP_OFF_HOLD1);
    chk("hold1_unsel", 32'h777, rv);
  endtask
  task automatic cmp_test();
    logic [3:0] m [4] = '{4'h8, 4'ha, 4'h9, 4'h2};
    logic e [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    wr(`CCP_OFF_CTRL0, 0);
    for (int i = 0; i < 4; i++) begin
      wr(`CCP_OFF_TIMER, 0);
      wr(`CCP_OFF_CTRL0, {28'h0, m[i]});
      wr(`CCP_OFF_HOLD0, 5);
      wr(`CCP_OFF_FLAGS, 3);
      wr(`CCP_OFF_TIMER, 5);
      repeat (3) @(posedge aclk);
      chk("cmp_pin", 32'(e[i]), 32'(p0o));
      rd(`CCP_OFF_FLAGS);
      chk("cmp_flag", 1, rv & 32'h1);
    end
  endtask
  task automatic special_test(input bit u);
    int start;
    adc_en <= 1;
    wr(`CCP_OFF_CTRL0, 0);
    wr(`CCP_OFF_CTRL1, 0);
    wr(u ? `CCP_OFF_HOLD1 : `CCP_OFF_HOLD0, 3);
    wr(`CCP_OFF_TIMER, 0);
    wr(u ? `CCP_OFF_CTRL1 : `CCP_OFF_CTRL0, 32'hb);
    if (u) begin
      chk("pad_c_oe_n", 0, 32'(pce));
      chk("pad_b_oe_n", 1, 32'(pbe));
      sel <= 1;
      @(posedge aclk);
      chk("pad_b_sel_oe_n", 0, 32'(pbe));
      chk("pad_c_unsel_oe_n", 1, 32'(pce));
      sel <= 0;
    end
    start = n_adc;
    wr(`CCP_OFF_TCTRL, 1);
    repeat (20) @(posedge aclk);
    wr(`CCP_OFF_TCTRL, 0);
    rd(`CCP_OFF_TIMER);
    chk("timer_cleared", 1, 32'(rv <= 3));
    chk("adc_started", 32'(u), 32'(n_adc > start));
  endtask
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    reg_test();
    cap_test();
    cmp_test();
    special_test(1);
    special_test(0);
    stop_test();
  end
endmodule
